// ### rtl/wcs_consts.svh
/*
  Constants for the wake input and cyclic-sense timer block: register offsets,
  field positions, reset values, mode codes and timing figures.
  Assumes a 20 MHz system clock and is included by the wcs_filter and wcs_top design files.
*/
`ifndef WCS_CONSTS_SVH
`define WCS_CONSTS_SVH

`define WCS_ADDR_PULL 7'h08
`define WCS_ADDR_FILT 7'h09
`define WCS_ADDR_TMR1 7'h0C
`define WCS_RESET_VAL 8'h00
`define WCS_ON_LSB 4
`define WCS_PER_LSB 0

`define WCS_ON_STOP_LOW 3'h0
`define WCS_ON_STOP_HIGH 3'h6
`define WCS_ON_RSVD 3'h7
`define WCS_FLT_STATIC16 2'h0
`define WCS_FLT_STATIC64 2'h1
`define WCS_FLT_CYCLIC1 2'h2
`define WCS_FLT_CYCLIC2 2'h3
`define WCS_HS_CYCLIC_TIMER_ONE 3'h2
`define WCS_HS_CYCLIC_TIMER_TWO 3'h3

`define WCS_CLK_PERIOD_NS 50
`define WCS_FLT_SHORT_NS 16000
`define WCS_FLT_LONG_NS 64000
`define WCS_TICK_NS 100000
`define WCS_FLT_SHORT_CYC ((`WCS_FLT_SHORT_NS + `WCS_CLK_PERIOD_NS - 1) / `WCS_CLK_PERIOD_NS)
`define WCS_FLT_LONG_CYC ((`WCS_FLT_LONG_NS + `WCS_CLK_PERIOD_NS - 1) / `WCS_CLK_PERIOD_NS)
`define WCS_TICK_CYC (`WCS_TICK_NS / `WCS_CLK_PERIOD_NS)

`define WCS_ON1_US 100
`define WCS_ON2_US 300
`define WCS_ON3_US 1000
`define WCS_ON4_US 10000
`define WCS_ON5_US 20000
`define WCS_PER0_MS 10
`define WCS_PER1_MS 20
`define WCS_PER2_MS 50
`define WCS_PER3_MS 100
`define WCS_PER4_MS 200
`define WCS_PER5_MS 1000
`define WCS_PER6_MS 2000
`endif

// ### rtl/wcs_pkg.sv
/*
  Types shared by the wake input and cyclic-sense timer block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package wcs_pkg;
  // Timer one state, one-hot.
  typedef enum logic [2:0] {
    WCS_STOP_LOW = 3'b001,
    WCS_STOP_HIGH = 3'b010,
    WCS_RUN = 3'b100
  } wcs_state_t;

  // One register access from the serial interface.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } wcs_req_t;

  // One-cycle wake events, one bit per source.
  typedef struct packed {
    logic cyclic_timer_two;
    logic cyclic_timer_one;
    logic wk3;
    logic wk2;
    logic wk1;
  } wcs_wake_t;
endpackage : wcs_pkg
`default_nettype wire

// ### rtl/wcs_filter.sv
/*
  Filter for one wake input: static 16 us or 64 us debounce, or 16 us filtered
  level taken at the end of a timer on-time.
  Assumes the raw level is already synchronous to clk_sys_in.
*/
`include "wcs_consts.svh"
`default_nettype none
module wcs_filter #(
  parameter int SHORT_CYC = `WCS_FLT_SHORT_CYC,
  parameter int LONG_CYC = `WCS_FLT_LONG_CYC
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic level_in,
  input wire logic [1:0] mode_in,
  input wire logic sample_one_in,
  input wire logic sample_two_in,
  output logic level_out
);
  logic [10:0] cnt_q;
  logic stable_q;
  logic lvl_q;
  wire [10:0] limit = (mode_in == `WCS_FLT_STATIC64) ? 11'(LONG_CYC - 1) : 11'(SHORT_CYC - 1);
  wire differs = level_in != stable_q;
  wire sample = (mode_in == `WCS_FLT_CYCLIC1) ? sample_one_in : sample_two_in;
  wire cyclic = mode_in[1];

  // A change is taken only after the raw level has differed for the whole filter time.
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q <= 11'h000;
      stable_q <= 1'b0;
    end else if (!differs) begin
      cnt_q <= 11'h000;
    end else if (cnt_q >= limit) begin
      cnt_q <= 11'h000;
      stable_q <= level_in;
    end else begin
      cnt_q <= cnt_q + 11'h001;
    end
  end

  // Cyclic modes expose the filtered level only at the on-time end, when the input is powered.
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lvl_q <= 1'b0;
    end else if (!cyclic || sample) begin
      lvl_q <= stable_q;
    end
  end
  assign level_out = lvl_q;

  a_static_filter_hold: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (!cyclic && differs && cnt_q < limit) |=> $stable(stable_q))
    else $error("Filtered level changed before the filter time elapsed.");
  a_cyclic_sample_only: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (cyclic && $past(cyclic) && !$past(sample)) |-> $stable(lvl_q))
    else $error("Cyclic level changed outside an on-time end.");
endmodule : wcs_filter
`default_nettype wire

// ### rtl/wcs_top.sv
/*
  Wake input configuration, wake filtering and cyclic timer one.
  Holds the pull, filter and timer one registers reached by the serial
  register port. Assumes the second timer, the switch registers, the wake
  enable register and the restart controller live outside and feed in here.
*/
`include "wcs_consts.svh"
`default_nettype none
module wcs_top #(
  parameter int TICK_CYC = `WCS_TICK_CYC
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic soft_reset_in,
  input wire wcs_pkg::wcs_req_t reg_req_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [2:0] wake_input_in,
  input wire logic [2:0] wake_enable_in,
  input wire logic measurement_select_in,
  input wire logic timer_one_wake_enable_in,
  input wire logic timer_two_wake_enable_in,
  input wire logic timer_two_level_in,
  input wire logic timer_two_on_end_in,
  input wire logic timer_two_period_in,
  input wire logic [11:0] hs_config_in,
  input wire logic restart_hs_clear_in,
  output logic [5:0] pull_select_out,
  output logic [2:0] wake_level_out,
  output logic timer_one_out,
  output logic [3:0] high_side_output_out,
  output wcs_pkg::wcs_wake_t wake_event_out
);
  logic [5:0] pull_q;
  logic [5:0] filt_q;
  logic [2:0] on_q;
  logic [2:0] per_q;
  logic [7:0] rdata_q;
  wcs_pkg::wcs_state_t st_q;
  wcs_pkg::wcs_state_t st_d;
  logic [11:0] pre_q;
  logic [15:0] cnt_q;
  logic t1_q;
  wire [2:0] lvl;
  logic [2:0] lvl_prev_q;
  logic [3:0] hs_q;
  wcs_pkg::wcs_wake_t wake_q;
  wcs_pkg::wcs_wake_t wake_d;

  // On-time in 0.1 ms ticks; codes outside 001 to 101 never run.
  function automatic logic [15:0] on_ticks(input logic [2:0] code);
    unique case (code)
      3'h1: on_ticks = 16'(`WCS_ON1_US * 1000 / `WCS_TICK_NS);
      3'h2: on_ticks = 16'(`WCS_ON2_US * 1000 / `WCS_TICK_NS);
      3'h3: on_ticks = 16'(`WCS_ON3_US * 1000 / `WCS_TICK_NS);
      3'h4: on_ticks = 16'(`WCS_ON4_US * 1000 / `WCS_TICK_NS);
      3'h5: on_ticks = 16'(`WCS_ON5_US * 1000 / `WCS_TICK_NS);
      default: on_ticks = 16'h0000;
    endcase
  endfunction : on_ticks

  // Period in 0.1 ms ticks; reserved code 111 behaves as the longest period.
  function automatic logic [15:0] per_ticks(input logic [2:0] code);
    unique case (code)
      3'h0: per_ticks = 16'(`WCS_PER0_MS * 1000000 / `WCS_TICK_NS);
      3'h1: per_ticks = 16'(`WCS_PER1_MS * 1000000 / `WCS_TICK_NS);
      3'h2: per_ticks = 16'(`WCS_PER2_MS * 1000000 / `WCS_TICK_NS);
      3'h3: per_ticks = 16'(`WCS_PER3_MS * 1000000 / `WCS_TICK_NS);
      3'h4: per_ticks = 16'(`WCS_PER4_MS * 1000000 / `WCS_TICK_NS);
      3'h5: per_ticks = 16'(`WCS_PER5_MS * 1000000 / `WCS_TICK_NS);
      default: per_ticks = 16'(`WCS_PER6_MS * 1000000 / `WCS_TICK_NS);
    endcase
  endfunction : per_ticks

  // Register port decode.
  wire wr_pull = reg_req_in.wr && (reg_req_in.addr == `WCS_ADDR_PULL);
  wire wr_filt = reg_req_in.wr && (reg_req_in.addr == `WCS_ADDR_FILT);
  wire wr_tmr = reg_req_in.wr && (reg_req_in.addr == `WCS_ADDR_TMR1);
  wire [2:0] cyc_mode = {filt_q[5], filt_q[3], filt_q[1]};
  wire tmr_clear = restart_hs_clear_in && (|cyc_mode);
  // Reserved positions are tied to zero in the read mux.
  wire [7:0] rd_mux = (reg_req_in.addr == `WCS_ADDR_PULL) ? {2'h0, pull_q} :
    (reg_req_in.addr == `WCS_ADDR_FILT) ? {2'h0, filt_q} :
    (reg_req_in.addr == `WCS_ADDR_TMR1) ? {1'b0, on_q, 1'b0, per_q} : `WCS_RESET_VAL;

  // Register file. Hardware clear beats a same-cycle software write to the timer.
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pull_q <= 6'h00;
      filt_q <= 6'h00;
      on_q <= 3'h0;
      per_q <= 3'h0;
      rdata_q <= 8'h00;
    end else if (soft_reset_in) begin
      pull_q <= 6'h00;
      filt_q <= 6'h00;
      on_q <= 3'h0;
      per_q <= 3'h0;
      rdata_q <= 8'h00;
    end else begin
      if (wr_pull) pull_q <= reg_req_in.wdata[5:0];
      if (wr_filt) filt_q <= reg_req_in.wdata[5:0];
      if (tmr_clear) begin
        on_q <= 3'h0;
        per_q <= 3'h0;
      end else if (wr_tmr) begin
        on_q <= reg_req_in.wdata[`WCS_ON_LSB +: 3];
        per_q <= reg_req_in.wdata[`WCS_PER_LSB +: 3];
      end
      if (reg_req_in.rd) rdata_q <= rd_mux;
    end
  end
  assign reg_rdata_out = rdata_q;
  assign pull_select_out = pull_q;

  // Timer state follows the on-time code; no start command exists.
  wire run_code = (on_q != `WCS_ON_STOP_LOW) && (on_q != `WCS_ON_STOP_HIGH) && (on_q != `WCS_ON_RSVD);
  assign st_d = run_code ? wcs_pkg::WCS_RUN :
    (on_q == `WCS_ON_STOP_HIGH) ? wcs_pkg::WCS_STOP_HIGH : wcs_pkg::WCS_STOP_LOW;
  wire running = st_q == wcs_pkg::WCS_RUN;
  wire tick = pre_q == 12'(TICK_CYC - 1);
  wire [15:0] on_len = on_ticks(on_q);
  wire [15:0] per_len = per_ticks(per_q);
  wire per_wrap = tick && (cnt_q >= per_len - 16'h0001);
  wire on_end = running && tick && (cnt_q == on_len - 16'h0001);
  wire per_start = running && (pre_q == 12'h000) && (cnt_q == 16'h0000);

  // Prescaler and period counter; both sit at zero while stopped so a start begins a fresh period.
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q <= wcs_pkg::WCS_STOP_LOW;
      pre_q <= 12'h000;
      cnt_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      pre_q <= (!running || tick) ? 12'h000 : pre_q + 12'h001;
      cnt_q <= (!running || per_wrap) ? 16'h0000 : (tick ? cnt_q + 16'h0001 : cnt_q);
    end
  end

  // Output high for the first on_len ticks of each period while running.
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      t1_q <= 1'b0;
    end else begin
      unique case (st_q)
        wcs_pkg::WCS_RUN: t1_q <= cnt_q < on_len;
        wcs_pkg::WCS_STOP_HIGH: t1_q <= 1'b1;
        wcs_pkg::WCS_STOP_LOW: t1_q <= 1'b0;
        default: t1_q <= 1'b0;
      endcase
    end
  end
  assign timer_one_out = t1_q;

  // One filter per wake input; the host must also route the chosen timer to a switch.
  for (genvar i = 0; i < 3; i++) begin : g_flt
    wcs_filter u_flt (
      .clk_sys_in(clk_sys_in),
      .rstn_in(rstn_in),
      .level_in(wake_input_in[i]),
      .mode_in(filt_q[2*i +: 2]),
      .sample_one_in(on_end),
      .sample_two_in(timer_two_on_end_in),
      .level_out(lvl[i])
    );
  end
  assign wake_level_out = lvl;

  // Switch timer routing, one 3-bit code per switch.
  wire [3:0] hs_d;
  for (genvar s = 0; s < 4; s++) begin : g_hs
    assign hs_d[s] = (hs_config_in[3*s +: 3] == `WCS_HS_CYCLIC_TIMER_ONE) ? t1_q :
      (hs_config_in[3*s +: 3] == `WCS_HS_CYCLIC_TIMER_TWO) ? timer_two_level_in : 1'b0;
  end

  // Wake events: filtered edges and timer periods; both timer paths run alongside cyclic sensing.
  wire wk1_ev = (lvl[0] != lvl_prev_q[0]) && wake_enable_in[0] && !measurement_select_in;
  wire wk2_ev = (lvl[1] != lvl_prev_q[1]) && wake_enable_in[1] && !measurement_select_in;
  wire wk3_ev = (lvl[2] != lvl_prev_q[2]) && wake_enable_in[2];
  wire tmr1_ev = per_start && timer_one_wake_enable_in;
  wire tmr2_ev = timer_two_period_in && timer_two_wake_enable_in;
  // One driver for the whole event word keeps the struct free of split drivers.
  assign wake_d = '{cyclic_timer_two: tmr2_ev, cyclic_timer_one: tmr1_ev, wk3: wk3_ev, wk2: wk2_ev, wk1: wk1_ev};

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lvl_prev_q <= 3'h0;
      hs_q <= 4'h0;
      wake_q <= '0;
    end else begin
      lvl_prev_q <= lvl;
      hs_q <= hs_d;
      wake_q <= wake_d;
    end
  end
  assign high_side_output_out = hs_q;
  assign wake_event_out = wake_q;

  a_soft_reset_clears: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    soft_reset_in |=> (pull_q == 6'h00 && filt_q == 6'h00 && on_q == 3'h0 && per_q == 3'h0))
    else $error("Soft reset left a register non-zero.");
  a_reserved_reads_zero: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (reg_req_in.rd && !soft_reset_in) |=> (rdata_q[7] == 1'b0 &&
      (($past(reg_req_in.addr) == `WCS_ADDR_TMR1) ? (rdata_q[3] == 1'b0) : (rdata_q[6] == 1'b0))))
    else $error("Reserved read bits are not zero.");
  a_stop_low_holds: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (on_q == `WCS_ON_STOP_LOW && $past(on_q) == `WCS_ON_STOP_LOW) |=> !t1_q)
    else $error("Timer one output high while stopped low.");
  a_stop_high_holds: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (on_q == `WCS_ON_STOP_HIGH && $past(on_q) == `WCS_ON_STOP_HIGH) |=> t1_q)
    else $error("Timer one output low while stopped high.");
  a_auto_start: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (run_code && !running) |=> (running && pre_q == 12'h000 && cnt_q == 16'h0000))
    else $error("Timer did not start on a running on-time code.");
  a_restart_clear: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (tmr_clear && !soft_reset_in) |=> (on_q == 3'h0 && per_q == 3'h0))
    else $error("Restart clear left timer fields set.");
  a_period_bound: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (running && $stable(per_q) && $past(running)) |-> cnt_q < per_ticks(per_q) || $past(cnt_q) >= per_len)
    else $error("Period counter passed the selected period.");
  a_on_phase_high: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (running && $past(running) && cnt_q == 16'h0000 && $stable(on_q)) |=> t1_q)
    else $error("Timer output low at period start.");
  a_switch_follows: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (hs_config_in[2:0] == `WCS_HS_CYCLIC_TIMER_ONE) |=> (hs_q[0] == $past(t1_q)))
    else $error("Switch one did not follow timer one.");
  a_meas_blocks_wake: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    measurement_select_in |=> (!wake_q.wk1 && !wake_q.wk2))
    else $error("Wake input 1 or 2 woke while measurement selected.");
  a_timer_wake_gate: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    wake_q.cyclic_timer_one |-> $past(timer_one_wake_enable_in) && $past(per_start))
    else $error("Timer one wake without enable or period start.");
endmodule : wcs_top
`default_nettype wire

// ### dv/wcs_host_model.sv
/*
  Host side of the register port: one-byte writes and reads on the parallel strobe.
  Assumes the device takes a request at the rising edge and answers a read one cycle later.
*/
`default_nettype none
module wcs_host_model (
  input wire logic clk_sys_in,
  input wire logic [7:0] reg_rdata_in,
  output var wcs_pkg::wcs_req_t reg_req_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle until the first task call.
  initial reg_req_out = '0;

  // The strobe is held across exactly one rising edge, so each call is a single access.
  task automatic write_reg(input logic [6:0] addr, input logic [7:0] data);
    @(negedge clk_sys_in);
    reg_req_out <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(negedge clk_sys_in);
    reg_req_out <= '0;
  endtask : write_reg

  // Read data is registered at the edge that takes the request, so it is settled here.
  task automatic read_reg(input logic [6:0] addr, output logic [7:0] data);
    @(negedge clk_sys_in);
    reg_req_out <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(negedge clk_sys_in);
    reg_req_out <= '0;
    data = reg_rdata_in;
  endtask : read_reg
endmodule : wcs_host_model
`default_nettype wire

// ### dv/tb_top.sv
/*
  Self-checking bench for the wake input and cyclic timer block.
  Assumes the host model drives the register port; other inputs change at falling edges.
*/
`include "wcs_consts.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK = 10;
  localparam int LIMIT = 90000;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  logic soft_reset_in = 1'b0;
  wcs_pkg::wcs_req_t reg_req;
  logic [7:0] rdata;
  logic [2:0] wake_input = 3'h0;
  logic [2:0] wake_enable = 3'h7;
  logic meas_sel = 1'b1;
  logic t2_on_end = 1'b0;
  logic restart_clr = 1'b0;
  logic [11:0] hs_config = 12'h000;
  logic t2_level = 1'b1;
  logic t2_period = 1'b0;
  logic t2_wk_en = 1'b0;
  logic [5:0] pull_sel;
  logic [2:0] wake_level;
  logic timer_one;
  logic [3:0] hs_out;
  wcs_pkg::wcs_wake_t wake_ev;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  int wk1_cnt = 0;
  int wk2_cnt = 0;
  int wk3_cnt = 0;
  int on_cyc[5] = '{`WCS_ON1_US / 100 * TICK, `WCS_ON2_US / 100 * TICK, `WCS_ON3_US / 100 * TICK,
                    `WCS_ON4_US / 100 * TICK, `WCS_ON5_US / 100 * TICK};
  int per_cyc[5] = '{`WCS_PER0_MS * 10 * TICK, `WCS_PER1_MS * 10 * TICK, `WCS_PER2_MS * 10 * TICK,
                     `WCS_PER3_MS * 10 * TICK, `WCS_PER3_MS * 10 * TICK};
  logic [2:0] per_code[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h3};

  always #25 clk_sys_in = ~clk_sys_in;

  wcs_top #(.TICK_CYC(TICK)) dut_u (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .soft_reset_in(soft_reset_in), .reg_req_in(reg_req),
    .reg_rdata_out(rdata), .wake_input_in(wake_input), .wake_enable_in(wake_enable),
    .measurement_select_in(meas_sel), .timer_one_wake_enable_in(1'b1), .timer_two_wake_enable_in(t2_wk_en),
    .timer_two_level_in(t2_level), .timer_two_on_end_in(t2_on_end), .timer_two_period_in(t2_period),
    .hs_config_in(hs_config), .restart_hs_clear_in(restart_clr), .pull_select_out(pull_sel),
    .wake_level_out(wake_level), .timer_one_out(timer_one), .high_side_output_out(hs_out),
    .wake_event_out(wake_ev)
  );

  wcs_host_model host_u (.clk_sys_in(clk_sys_in), .reg_rdata_in(rdata), .reg_req_out(reg_req));

  // Wake pulses are counted here; wk1 and wk3 tests compare differences, wk2 its total, so nothing is reset mid-run.
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (wake_ev.wk1 === 1'b1) wk1_cnt <= wk1_cnt + 1;
    if (wake_ev.wk2 === 1'b1) wk2_cnt <= wk2_cnt + 1;
    if (wake_ev.wk3 === 1'b1) wk3_cnt <= wk3_cnt + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      $display("Timeout after %0d cycles", cycles);
      tally_and_finish();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [6:0] addr, input logic [7:0] exp);
    logic [7:0] v;
    host_u.read_reg(addr, v);
    chk({8'h00, v}, {8'h00, exp});
  endtask : rd_chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask : cyc

  // Bounded waits only: an idle timer shows up as wrong counts instead of a hang.
  task automatic measure(input int on_exp, input int per_exp);
    int n;
    int p;
    int w;
    n = 0;
    p = 0;
    w = 0;
    while (timer_one === 1'b1 && p < 2 * per_exp) begin
      p++;
      @(negedge clk_sys_in);
    end
    while (timer_one !== 1'b1 && p < 4 * per_exp) begin
      p++;
      @(negedge clk_sys_in);
    end
    while (timer_one === 1'b1 && n < 2 * per_exp) begin
      n++;
      w += int'(wake_ev.cyclic_timer_one);
      @(negedge clk_sys_in);
    end
    p = n;
    while (timer_one === 1'b0 && p < 2 * per_exp) begin
      p++;
      w += int'(wake_ev.cyclic_timer_one);
      @(negedge clk_sys_in);
    end
    chk(16'(n), 16'(on_exp));
    chk(16'(p), 16'(per_exp));
    chk(16'(w), 16'h0001);
  endtask : measure

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  initial begin : main
    int base;
    cyc(16);
    rstn_in = 1'b1;
    cyc(2);
    // Reset values, field placement and reserved bits.
    rd_chk(`WCS_ADDR_PULL, 8'h00);
    rd_chk(`WCS_ADDR_FILT, 8'h00);
    rd_chk(`WCS_ADDR_TMR1, 8'h00);
    host_u.write_reg(`WCS_ADDR_PULL, 8'hFF);
    rd_chk(`WCS_ADDR_PULL, 8'h3F);
    host_u.write_reg(`WCS_ADDR_PULL, 8'h1B);
    chk({10'h000, pull_sel}, 16'h001B);
    host_u.write_reg(`WCS_ADDR_FILT, 8'hFF);
    rd_chk(`WCS_ADDR_FILT, 8'h3F);
    host_u.write_reg(`WCS_ADDR_TMR1, 8'hFF);
    rd_chk(`WCS_ADDR_TMR1, 8'h77);
    rd_chk(7'h0A, 8'h00);
    soft_reset_in = 1'b1;
    cyc(1);
    soft_reset_in = 1'b0;
    cyc(2);
    rd_chk(`WCS_ADDR_PULL, 8'h00);
    rd_chk(`WCS_ADDR_FILT, 8'h00);
    rd_chk(`WCS_ADDR_TMR1, 8'h00);
    chk({10'h000, pull_sel}, 16'h0000);
    // A second power-on reset in mid-run must clear a written register as well.
    host_u.write_reg(`WCS_ADDR_PULL, 8'h2A);
    rstn_in = 1'b0;
    cyc(2);
    rstn_in = 1'b1;
    cyc(2);
    rd_chk(`WCS_ADDR_PULL, 8'h00);
    $display("Test registers done");
    // Static filters on input one, which cannot wake while measurement is selected.
    base = wk1_cnt;
    wake_input[0] = 1'b1;
    cyc(300);
    chk({15'h0, wake_level[0]}, 16'h0000);
    cyc(40);
    chk({15'h0, wake_level[0]}, 16'h0001);
    host_u.write_reg(`WCS_ADDR_FILT, 8'h01);
    wake_input[0] = 1'b0;
    cyc(1250);
    chk({15'h0, wake_level[0]}, 16'h0001);
    cyc(50);
    chk({15'h0, wake_level[0]}, 16'h0000);
    chk(16'(wk1_cnt - base), 16'h0000);
    $display("Test static filters done");
    // Inputs one and two wake once measurement is released; timer two wakes only while enabled.
    base = wk1_cnt;
    meas_sel = 1'b0;
    wake_input[1:0] = 2'h3;
    cyc(1300);
    chk(16'(wk1_cnt - base), 16'h0001);
    chk(16'(wk2_cnt), 16'h0001);
    t2_wk_en = 1'b1;
    t2_period = 1'b1;
    cyc(1);
    t2_period = 1'b0;
    chk({15'h0, wake_ev.cyclic_timer_two}, 16'h0001);
    cyc(1);
    chk({15'h0, wake_ev.cyclic_timer_two}, 16'h0000);
    t2_wk_en = 1'b0;
    t2_period = 1'b1;
    cyc(1);
    t2_period = 1'b0;
    chk({15'h0, wake_ev.cyclic_timer_two}, 16'h0000);
    $display("Test wake sources done");
    // Switch 0 on timer one, switch 1 on timer two, switch 3 on code 001, which drives it low.
    hs_config = 12'h21A;
    host_u.write_reg(`WCS_ADDR_TMR1, 8'h60);
    cyc(4);
    chk({12'h000, hs_out}, 16'h0003);
    t2_level = 1'b0;
    host_u.write_reg(`WCS_ADDR_TMR1, 8'h00);
    cyc(4);
    chk({12'h000, hs_out}, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      host_u.write_reg(`WCS_ADDR_TMR1, {1'b0, 3'(i + 1), 1'b0, per_code[i]});
      measure(on_cyc[i], per_cyc[i]);
    end
    $display("Test timer codes done");
    // Cyclic sensing on input three, first with timer one, then with timer two.
    host_u.write_reg(`WCS_ADDR_TMR1, 8'h10);
    host_u.write_reg(`WCS_ADDR_FILT, 8'h20);
    measure(on_cyc[0], per_cyc[0]);
    base = wk3_cnt;
    wake_input[2] = 1'b1;
    cyc(500);
    chk({15'h0, wake_level[2]}, 16'h0000);
    measure(on_cyc[0], per_cyc[0]);
    cyc(3);
    chk({15'h0, wake_level[2]}, 16'h0001);
    host_u.write_reg(`WCS_ADDR_FILT, 8'h30);
    wake_input[2] = 1'b0;
    cyc(1100);
    chk({15'h0, wake_level[2]}, 16'h0001);
    t2_on_end = 1'b1;
    cyc(1);
    t2_on_end = 1'b0;
    cyc(3);
    chk({15'h0, wake_level[2]}, 16'h0000);
    chk(16'(wk3_cnt - base), 16'h0002);
    restart_clr = 1'b1;
    cyc(1);
    restart_clr = 1'b0;
    cyc(2);
    rd_chk(`WCS_ADDR_TMR1, 8'h00);
    cyc(2);
    chk({15'h0, timer_one}, 16'h0000);
    $display("Test cyclic sensing done");
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
